// ### logic/smf_pkg.sv
// Purpose: shared constants and types for the sequential muting sequencer
// Assumes: one sensor sample per pclk cycle, 200 MHz clock
// Notes: diagnostic codes follow the state/error code plan of the block
package smf_pkg;
  // apb register offsets
  localparam logic [7:0] SMF_OFF_CTRL = 8'h00;
  localparam logic [7:0] SMF_OFF_LIMIT = 8'h04;
  localparam logic [7:0] SMF_OFF_STATUS = 8'h08;
  localparam logic [7:0] SMF_OFF_DIAG = 8'h0C;
  // ctrl field positions
  localparam int SMF_CTRL_ACTIVATE = 0;
  localparam int SMF_CTRL_RESET = 1;
  localparam int SMF_CTRL_AUTO = 2;
  // status field positions
  localparam int SMF_ST_READY = 0;
  localparam int SMF_ST_PDOK = 1;
  localparam int SMF_ST_MUTE = 2;
  localparam int SMF_ST_ERROR = 3;
  // limit: milliseconds, 0 to 10 min
  localparam logic [31:0] SMF_LIMIT_MAX_MS = 32'h000927C0;
  localparam logic [31:0] SMF_LIMIT_RESET = 32'h00000000;
  localparam int SMF_CLK_MHZ = 200;
  localparam int SMF_MS_CYCLES = SMF_CLK_MHZ * 1000;
  // diagnostic codes
  localparam logic [15:0] SMF_DC_IDLE = 16'h0000;
  localparam logic [15:0] SMF_DC_INIT = 16'h8001;
  localparam logic [15:0] SMF_DC_WAIT = 16'h8003;
  localparam logic [15:0] SMF_DC_ST8000 = 16'h8000;
  localparam logic [15:0] SMF_DC_ST8011 = 16'h8011;
  localparam logic [15:0] SMF_DC_ST8012 = 16'h8012;
  localparam logic [15:0] SMF_DC_ST8122 = 16'h8122;
  localparam logic [15:0] SMF_DC_ST8112 = 16'h8112;
  localparam logic [15:0] SMF_DC_DEMAND = 16'h8004;
  localparam logic [15:0] SMF_DC_LAMP = 16'hC003;
  localparam logic [15:0] SMF_DC_PARAM = 16'hC005;
  localparam logic [15:0] SMF_DC_TIMER = 16'hC006;
  localparam logic [15:0] SMF_DC_SEQ = 16'hC004;
  localparam logic [3:0] SMF_SEQ_Y_8000 = 4'h0;
  localparam logic [3:0] SMF_SEQ_Y_8011 = 4'h1;
  localparam logic [3:0] SMF_SEQ_Y_8012 = 4'h2;
  localparam logic [3:0] SMF_SEQ_Y_8122 = 4'h3;
  localparam logic [3:0] SMF_SEQ_Y_8112 = 4'h4;
  localparam logic [3:0] SMF_SEQ_Y_PERMIT = 4'hF;
  localparam int SMF_Y_LSB = 8;
  localparam int SMF_X_LSB = 4;
endpackage

// ### logic/smf_sensor_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ps
module smf_sensor_sync
  import smf_pkg::*;
#(
  parameter int WIDTH = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  // one filter per input bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        level_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// ### logic/smf_mute_timer.sv
// Purpose: maximum muting time counter in milliseconds
// Assumes: limit already range checked by the caller
// Notes: expired stays high while running past the limit
`timescale 1ns/1ps
module smf_mute_timer
  import smf_pkg::*;
#(
  parameter int MS_CYCLES = SMF_MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [31:0] limit_ms,
  output logic expired
);
  logic [31:0] pre_q;
  logic [31:0] ms_q;
  // prescaler and millisecond count, cleared whenever stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 32'h00000000;
      ms_q <= 32'h00000000;
    end else if (!run) begin
      pre_q <= 32'h00000000;
      ms_q <= 32'h00000000;
    end else if (pre_q == 32'(MS_CYCLES - 1)) begin
      pre_q <= 32'h00000000;
      if (ms_q <= limit_ms) begin
        ms_q <= ms_q + 32'h00000001;
      end
    end else begin
      pre_q <= pre_q + 32'h00000001;
    end
  end
  // longer than the limit once count passes it
  assign expired = run && (ms_q > limit_ms);
endmodule

// ### logic/smf_muting_seq.sv
// Purpose: four-sensor sequential muting sequencer with apb control
// Assumes: sensors, curtain, lamp and permit arrive on asynchronous pins
// Notes: control, limit, status and diagnostic code are apb registers
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module smf_muting_seq
  import smf_pkg::*;
#(
  parameter int MS_CYCLES = SMF_MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic protective_device_ok_in,
  input wire logic sensor_one_one,
  input wire logic sensor_one_two,
  input wire logic sensor_two_one,
  input wire logic sensor_two_two,
  input wire logic indicator_lamp_ok,
  input wire logic muting_permit,
  output logic ready_q,
  output logic protective_device_ok_out,
  output logic muting_active,
  output logic error_q,
  output logic [15:0] diagnostic_code
);
  typedef enum logic [3:0] {
    IDLE, INIT, WAIT_RESET, ST8000, ST8011, ST8012, ST8122, ST8112, DEMAND, ERR
  } smf_state_type;
  smf_state_type state_q;
  smf_state_type state_d;
  logic [15:0] code_d;
  logic [5:0] pins;
  logic [5:0] lvl;
  logic [3:0] prev_q;
  logic [3:0] s;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [2:0] ctrl_q;
  logic [31:0] limit_q;
  logic reset_prev_q;
  logic reset_rise;
  logic timer_run;
  logic timer_exp;
  logic param_bad;
  logic seq_err;
  logic [3:0] seq_y;
  logic muting_st;
  logic pd_in;
  logic lamp;
  logic wr_en;

  assign pins = {indicator_lamp_ok, protective_device_ok_in, sensor_two_two, sensor_two_one,
                 sensor_one_two, sensor_one_one};
  // pin inputs through the agreement filter
  smf_sensor_sync #(.WIDTH(6)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pins),
    .level_q(lvl)
  );
  logic permit;
  smf_sensor_sync #(.WIDTH(1)) u_sync_permit (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(muting_permit),
    .level_q(permit)
  );
  assign s = lvl[3:0]; // bit 0 sensor 11 .. bit 3 sensor 22
  assign pd_in = lvl[4];
  assign lamp = lvl[5];

  // previous levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 4'h0;
      reset_prev_q <= 1'b0;
    end else begin
      prev_q <= s;
      reset_prev_q <= ctrl_q[SMF_CTRL_RESET];
    end
  end
  assign rise = s & ~prev_q;
  assign fall = ~s & prev_q;
  assign reset_rise = ctrl_q[SMF_CTRL_RESET] && !reset_prev_q;

  // apb slave, zero wait states
  assign wr_en = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 3'h0;
      limit_q <= SMF_LIMIT_RESET;
    end else if (wr_en) begin
      if (paddr == SMF_OFF_CTRL) begin
        ctrl_q <= pwdata[2:0];
      end
      if (paddr == SMF_OFF_LIMIT) begin
        limit_q <= pwdata;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          SMF_OFF_CTRL: prdata <= {29'h0, ctrl_q};
          SMF_OFF_LIMIT: prdata <= limit_q;
          SMF_OFF_STATUS: prdata <= {28'h0, error_q, muting_active,
                                     protective_device_ok_out, ready_q};
          SMF_OFF_DIAG: prdata <= {16'h0, diagnostic_code};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // limit range check and timer
  assign param_bad = limit_q > SMF_LIMIT_MAX_MS;
  assign muting_st = (state_q == ST8011) || (state_q == ST8012) ||
                     (state_q == ST8122) || (state_q == ST8112);
  assign timer_run = muting_st; // runs from first sensor until exit
  smf_mute_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(timer_run),
    .limit_ms(limit_q),
    .expired(timer_exp)
  );

  // illegal sequence per state; shorts look the same
  always_comb begin
    seq_err = 1'b0;
    seq_y = SMF_SEQ_Y_8000;
    case (state_q)
      ST8000: begin
        if (!permit && (rise[0] || rise[3])) begin
          seq_err = 1'b1;
          seq_y = SMF_SEQ_Y_PERMIT;
        end else if (s[1] || s[2] || (s[0] && s[3])) begin
          seq_err = 1'b1;
        end
      end
      ST8011: begin
        seq_y = SMF_SEQ_Y_8011;
        seq_err = !permit || !s[0] || s[2] || s[3];
      end
      ST8012: begin
        seq_y = SMF_SEQ_Y_8012;
        seq_err = rise[0] || rise[1] || fall[3];
      end
      ST8122: begin
        seq_y = SMF_SEQ_Y_8122;
        seq_err = !permit || s[0] || s[1] || !s[3];
      end
      ST8112: begin
        seq_y = SMF_SEQ_Y_8112;
        seq_err = fall[0] || rise[2] || rise[3];
      end
      default: begin
        seq_err = 1'b0;
      end
    endcase
  end

  // next state and diagnostic code
  always_comb begin
    state_d = state_q;
    code_d = diagnostic_code;
    if (!ctrl_q[SMF_CTRL_ACTIVATE]) begin
      state_d = IDLE;
      code_d = SMF_DC_IDLE;
    end else begin
      case (state_q)
        IDLE: begin
          state_d = INIT;
          code_d = SMF_DC_INIT;
        end
        INIT: begin
          if (param_bad) begin
            state_d = ERR;
            code_d = SMF_DC_PARAM;
          end else if (ctrl_q[SMF_CTRL_AUTO]) begin
            state_d = ST8000;
            code_d = SMF_DC_ST8000;
          end else if (reset_rise) begin
            state_d = ST8000;
            code_d = SMF_DC_ST8000;
          end
        end
        WAIT_RESET, DEMAND: begin
          if (reset_rise && pd_in) begin
            state_d = ST8000;
            code_d = SMF_DC_ST8000;
          end
        end
        ERR: begin
          if (!param_bad && reset_rise) begin
            state_d = WAIT_RESET;
            code_d = SMF_DC_WAIT;
          end
        end
        ST8000, ST8011, ST8012, ST8122, ST8112: begin
          if (param_bad) begin
            state_d = ERR;
            code_d = SMF_DC_PARAM;
          end else if (seq_err) begin
            state_d = ERR;
            code_d = {SMF_DC_SEQ[15:12], seq_y, s, SMF_DC_SEQ[3:0]};
          end else if (timer_exp) begin
            state_d = ERR;
            code_d = SMF_DC_TIMER;
          end else if (!pd_in && !muting_st) begin
            state_d = DEMAND;
            code_d = SMF_DC_DEMAND;
          end else if (!lamp && muting_st) begin
            state_d = ERR;
            code_d = SMF_DC_LAMP;
          end else begin
            case (state_q)
              ST8000: begin
                if (permit && rise[0] && !s[1] && !s[2] && !s[3]) begin
                  state_d = ST8011;
                  code_d = SMF_DC_ST8011;
                end else if (permit && rise[3] && !s[0] && !s[1] && !s[2]) begin
                  state_d = ST8122;
                  code_d = SMF_DC_ST8122;
                end
              end
              ST8011: begin
                if (permit && s[0] && rise[1] && !s[2] && !s[3]) begin
                  state_d = ST8012;
                  code_d = SMF_DC_ST8012;
                end
              end
              ST8012: begin
                if (!s[0] && !s[1] && fall[2] && s[3]) begin
                  state_d = ST8000;
                  code_d = SMF_DC_ST8000;
                end
              end
              ST8122: begin
                if (permit && !s[0] && !s[1] && rise[2] && s[3]) begin
                  state_d = ST8112;
                  code_d = SMF_DC_ST8112;
                end
              end
              ST8112: begin
                if (s[0] && fall[1] && !s[2] && !s[3]) begin
                  state_d = ST8000;
                  code_d = SMF_DC_ST8000;
                end
              end
              default: begin
                state_d = ST8000;
              end
            endcase
          end
        end
        default: begin
          state_d = IDLE;
          code_d = SMF_DC_IDLE;
        end
      endcase
    end
  end

  // state and registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= IDLE;
      diagnostic_code <= 16'h0000;
      ready_q <= 1'b0;
      protective_device_ok_out <= 1'b0;
      muting_active <= 1'b0;
      error_q <= 1'b0;
    end else begin
      state_q <= state_d;
      diagnostic_code <= code_d;
      ready_q <= ctrl_q[SMF_CTRL_ACTIVATE];
      error_q <= (state_d == ERR);
      muting_active <= (state_d == ST8011) || (state_d == ST8012) ||
                       (state_d == ST8122) || (state_d == ST8112);
      protective_device_ok_out <= (state_d == ST8011) || (state_d == ST8012) ||
                                  (state_d == ST8122) || (state_d == ST8112) ||
                                  ((state_d == ST8000) && pd_in);
    end
  end

  // assertions
  property p_err_outputs;
    @(posedge pclk) disable iff (!presetn)
      error_q |-> (!protective_device_ok_out && !muting_active);
  endproperty
  a_err_outputs: assert property (p_err_outputs) else $error("outputs high in error");

  property p_mute_state;
    @(posedge pclk) disable iff (!presetn)
      muting_active |-> $past(muting_st) || muting_st;
  endproperty
  a_mute_state: assert property (p_mute_state) else $error("muting outside substate");

  property p_pd_ok;
    @(posedge pclk) disable iff (!presetn)
      (protective_device_ok_out && !muting_active) |-> state_q == ST8000;
  endproperty
  a_pd_ok: assert property (p_pd_ok) else $error("pd ok without idle or muting");

  property p_deact;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_q[SMF_CTRL_ACTIVATE] |=> state_q == IDLE && !error_q;
  endproperty
  a_deact: assert property (p_deact) else $error("not idle after deactivate");

  property p_fwd_start;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_q[SMF_CTRL_ACTIVATE] && state_q == ST8000 && !param_bad && pd_in &&
       permit && rise[0] && s[3:1] == 3'h0) |=> state_q == ST8011 && muting_active;
  endproperty
  a_fwd_start: assert property (p_fwd_start) else $error("forward start missed");

  property p_bwd_start;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_q[SMF_CTRL_ACTIVATE] && state_q == ST8000 && !param_bad && pd_in &&
       permit && rise[3] && s[2:0] == 3'h0) |=> state_q == ST8122;
  endproperty
  a_bwd_start: assert property (p_bwd_start) else $error("backward start missed");

  property p_seq_code;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_q[SMF_CTRL_ACTIVATE] && muting_st && !param_bad && seq_err) |=>
        error_q && diagnostic_code[7:4] == $past(s);
  endproperty
  a_seq_code: assert property (p_seq_code) else $error("sequence code wrong");

  property p_no_permit;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST8000 && !permit) |=> !(state_q inside {ST8011, ST8122});
  endproperty
  a_no_permit: assert property (p_no_permit) else $error("muting began without permit");

  property p_timer_err;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_q[SMF_CTRL_ACTIVATE] && muting_st && !param_bad && !seq_err && timer_exp) |=>
        diagnostic_code == SMF_DC_TIMER;
  endproperty
  a_timer_err: assert property (p_timer_err) else $error("timer error not ranked");
endmodule

// ### tb/smf_field_model.sv
// Purpose: field side model: four muting sensors, light curtain, lamp and permit
// Assumes: the bench calls drive and env; levels change right after a rising edge
// Notes: sensor bit 0 is the outer entry sensor, bit 3 the outer exit sensor
`timescale 1ns/1ps
module smf_field_model (
  input wire logic pclk,
  output logic [3:0] sensors,
  output logic curtain_clear,
  output logic lamp_ok,
  output logic permit
);
  // idle field: nothing covered, curtain clear, lamp good, permit given
  initial begin
    sensors = 4'h0;
    curtain_clear = 1'b1;
    lamp_ok = 1'b1;
    permit = 1'b1; // process control grants muting whenever it is intended
  end
  // new sensor levels, held long enough to cross the pin synchroniser
  task automatic drive(input logic [3:0] s);
    @(posedge pclk);
    sensors <= s;
    repeat (10) @(posedge pclk);
  endtask
  // curtain, lamp and permit levels
  task automatic env(input logic c, input logic l, input logic p);
    @(posedge pclk);
    curtain_clear <= c;
    lamp_ok <= l;
    permit <= p; // permit withdrawn only where a refusal is wanted
  endtask
endmodule

// ### tb/tb_smf_muting_seq.sv
// Purpose: self-checking bench for the sequential muting sequencer
// Assumes: MS_CYCLES set to 2, so one millisecond of limit is two clocks
// Notes: registers are reached over apb; field levels come from the model
`timescale 1ns/1ps
module tb_smf_muting_seq
  import smf_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic ready_q, pdok, muting_active, error_q, curtain, lamp, permit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] diagnostic_code;
  logic [3:0] sens;
  int miscompares, total_checks, cycles;

  smf_field_model fm (.pclk(pclk), .sensors(sens), .curtain_clear(curtain),
    .lamp_ok(lamp), .permit(permit));

  smf_muting_seq #(.MS_CYCLES(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .protective_device_ok_in(curtain), .sensor_one_one(sens[0]),
    .sensor_one_two(sens[1]), .sensor_two_one(sens[2]), .sensor_two_two(sens[3]),
    .indicator_lamp_ok(lamp), .muting_permit(permit), .ready_q(ready_q),
    .protective_device_ok_out(pdok), .muting_active(muting_active),
    .error_q(error_q), .diagnostic_code(diagnostic_code));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic wrap_up();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard, far above the under two thousand cycles the run needs
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait a bounded time for a code, then compare all safety outputs with it
  task automatic expect_state(input logic [15:0] c, input logic p, input logic m,
                              input logic e);
    int n;
    n = 0;
    while (diagnostic_code !== c && n < 40) begin
      @(negedge pclk);
      n++;
    end
    @(negedge pclk);
    chk({13'h0, error_q, muting_active, pdok, diagnostic_code}, {13'h0, e, m, p, c});
  endtask

  // clear the field, then two reset rises: error to wait, wait to 8000
  task automatic recover();
    fm.env(1'b1, 1'b1, 1'b1);
    fm.drive(4'h0);
    apb(1'b1, SMF_OFF_CTRL, 32'h00000005);
    apb(1'b1, SMF_OFF_CTRL, 32'h00000007);
    apb(1'b1, SMF_OFF_CTRL, 32'h00000005);
    apb(1'b1, SMF_OFF_CTRL, 32'h00000007);
    expect_state(SMF_DC_ST8000, 1'b1, 1'b0, 1'b0);
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(posedge pclk);
    expect_state(SMF_DC_IDLE, 1'b0, 1'b0, 1'b0);
    presetn <= 1'b1;
    apb(1'b0, SMF_OFF_STATUS, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h00000001);
    apb(1'b1, SMF_OFF_LIMIT, 32'h000003E8);
    apb(1'b0, SMF_OFF_LIMIT, 32'h0);
    chk(rd, 32'h000003E8);
    // activate with auto start: nothing is covered, so starting is safe
    apb(1'b1, SMF_OFF_CTRL, 32'h00000005);
    expect_state(SMF_DC_ST8000, 1'b1, 1'b0, 1'b0);
    apb(1'b0, SMF_OFF_STATUS, 32'h0);
    chk(rd, 32'h00000003);
    chk({31'h0, ready_q}, 32'h00000001);
    // forward passage
    fm.drive(4'h1);
    expect_state(SMF_DC_ST8011, 1'b1, 1'b1, 1'b0);
    apb(1'b0, SMF_OFF_DIAG, 32'h0);
    chk(rd, {16'h0, SMF_DC_ST8011});
    fm.drive(4'h3);
    expect_state(SMF_DC_ST8012, 1'b1, 1'b1, 1'b0);
    fm.drive(4'h7);
    fm.drive(4'hF);
    fm.drive(4'hE);
    fm.drive(4'hC);
    expect_state(SMF_DC_ST8012, 1'b1, 1'b1, 1'b0);
    fm.drive(4'h8);
    expect_state(SMF_DC_ST8000, 1'b1, 1'b0, 1'b0);
    fm.drive(4'h0);
    // backward passage
    fm.drive(4'h8);
    expect_state(SMF_DC_ST8122, 1'b1, 1'b1, 1'b0);
    fm.drive(4'hC);
    expect_state(SMF_DC_ST8112, 1'b1, 1'b1, 1'b0);
    fm.drive(4'hE);
    fm.drive(4'hF);
    fm.drive(4'h7);
    fm.drive(4'h3);
    expect_state(SMF_DC_ST8112, 1'b1, 1'b1, 1'b0);
    fm.drive(4'h1);
    expect_state(SMF_DC_ST8000, 1'b1, 1'b0, 1'b0);
    fm.drive(4'h0);
    // start without permit
    fm.env(1'b1, 1'b1, 1'b0);
    fm.drive(4'h1);
    expect_state(16'hCF14, 1'b0, 1'b0, 1'b1);
    recover();
    // exit sensor in 8011 together with a lamp failure: sequence error wins
    fm.drive(4'h1);
    fork
      fm.env(1'b1, 1'b0, 1'b1);
      fm.drive(4'h5);
    join
    expect_state(16'hC154, 1'b0, 1'b0, 1'b1);
    recover();
    // inner entry sensor covered in 8122
    fm.drive(4'h8);
    fm.drive(4'hA);
    expect_state(16'hC3A4, 1'b0, 1'b0, 1'b1);
    recover();
    // 5 ms limit, ten clocks, runs out in 8011
    apb(1'b1, SMF_OFF_LIMIT, 32'h00000005);
    fm.drive(4'h1);
    expect_state(SMF_DC_TIMER, 1'b0, 1'b0, 1'b1);
    apb(1'b1, SMF_OFF_LIMIT, 32'h000003E8);
    recover();
    // deactivate in mid-muting
    fm.drive(4'h1);
    expect_state(SMF_DC_ST8011, 1'b1, 1'b1, 1'b0);
    apb(1'b1, SMF_OFF_CTRL, 32'h00000000);
    expect_state(SMF_DC_IDLE, 1'b0, 1'b0, 1'b0);
    chk({31'h0, ready_q}, 32'h00000000);
    fm.drive(4'h0);
    // curtain broken outside muting
    apb(1'b1, SMF_OFF_CTRL, 32'h00000005);
    expect_state(SMF_DC_ST8000, 1'b1, 1'b0, 1'b0);
    fm.env(1'b0, 1'b1, 1'b1);
    expect_state(SMF_DC_DEMAND, 1'b0, 1'b0, 1'b0);
    wrap_up();
  end
endmodule
